// ==== rtl/fpc_pkg.sv ====
// Constants shared by the four-channel pwm clocking front end
package fpc_pkg;
   localparam int unsigned ADDR_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CLKP  = 8'h40;
   localparam logic [7:0] IDX_POL   = 8'h41;
   localparam logic [7:0] IDX_EN    = 8'h42;
   localparam logic [7:0] IDX_PRES  = 8'h43;
   localparam logic [7:0] IDX_SCAL0 = 8'h44;
   localparam logic [7:0] IDX_SCNT0 = 8'h45;
   localparam logic [7:0] IDX_SCAL1 = 8'h46;
   localparam logic [7:0] IDX_SCNT1 = 8'h47;
   localparam logic [7:0] IDX_CNT0  = 8'h48;
   localparam logic [7:0] IDX_PER0  = 8'h4C;
   localparam logic [7:0] IDX_DTY0  = 8'h50;
   localparam logic [7:0] IDX_CTL   = 8'h54;
   // Field positions
   localparam int unsigned UPPER_JOIN_BIT = 7;
   localparam int unsigned LOWER_JOIN_BIT = 6;
   localparam int unsigned DIVA_LSB       = 3;
   localparam int unsigned DIVB_LSB       = 0;
   localparam int unsigned CHOICE_LSB     = 4;
   localparam int unsigned POL_LSB        = 0;
   localparam int unsigned CENTER_BIT     = 0;
   // Reset values
   localparam logic [7:0] RST_CLKP = 8'h00;
   localparam logic [7:0] RST_POL  = 8'h00;
   localparam logic [3:0] RST_EN   = 4'h0;
   localparam logic [7:0] RST_SCAL = 8'h00;
   localparam logic [7:0] RST_PER  = 8'hFF;
   localparam logic [7:0] RST_DTY  = 8'hFF;
   localparam logic [7:0] RST_CTL  = 8'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== rtl/fpc_top.sv ====
// Four-channel pwm clocking, pairing and waveform core with AXI4-Lite
// Summary of operation
// - Four 8-bit channels, pairable into 16-bit ones, each with counter.
// - Duty spans fully off to fully on; left or center alignment.
// - While enabled, new period/duty waits in buffer until rollover.
// - While disabled, period/duty writes reach buffer and latch together.
// - Counter write clears counter and loads buffered period and duty.
// - Counters are readable by software at any time.
// - Enabled channel takes over its port pin from general-purpose logic.
// - Upper join: ch2 high byte, ch3 low, ch3 clock, ch2 pin.
// - Lower join: ch0 high byte, ch1 low, ch1 clock, ch0 pin.
// - Clock A is input clock divided by two to the field value.
// - Clock B likewise; B serves channels 2,3 and A channels 0,1.
// - Channels 3,2 choose clock B on 0, scaled high clock on 1.
// - Channels 1,0 choose clock A on 0, scaled low clock on 1.
// - Changing clock choice mid-waveform may give one odd pulse.
// - Left-aligned polarity 0 starts low, goes high at duty match.
// - Duty counts high time at left-aligned polarity 1, low time otherwise.
// - Scaled low clock is clock A over scale plus one, over two.
// - Scaled high clock is clock B over scale plus one, over two.
// - Enables gate channel clocks; prescaler stops when all disabled.
// - Period is clock times value plus one, or twice value centered.
`timescale 1ns/1ps
module fpc_top (
   // Clock and reset
   input  wire logic                       clk_in,
   input  wire logic                       arst_n_in,
   // AXI4-Lite write address
   input  wire logic [fpc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic                       s_axi_awvalid_in,
   output wire logic                       s_axi_awready_out,
   // AXI4-Lite write data
   input  wire logic [31:0]                s_axi_wdata_in,
   input  wire logic [3:0]                 s_axi_wstrb_in,
   input  wire logic                       s_axi_wvalid_in,
   output wire logic                       s_axi_wready_out,
   // AXI4-Lite write response
   output wire logic [1:0]                 s_axi_bresp_out,
   output wire logic                       s_axi_bvalid_out,
   input  wire logic                       s_axi_bready_in,
   // AXI4-Lite read
   input  wire logic [fpc_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic                       s_axi_arvalid_in,
   output wire logic                       s_axi_arready_out,
   output wire logic [31:0]                s_axi_rdata_out,
   output wire logic [1:0]                 s_axi_rresp_out,
   output wire logic                       s_axi_rvalid_out,
   input  wire logic                       s_axi_rready_in,
   // Port pins
   input  wire logic [3:0]                 gp_data_in,
   input  wire logic [3:0]                 gp_oe_in,
   output wire logic [3:0]                 pin_out,
   output wire logic [3:0]                 pin_oe_out
);
   // Bus state
   logic        aw_full_r, w_full_r, aw_bad_r, w_lane_r;
   logic        bvalid_r, rvalid_r;
   logic [7:0]  aw_idx_r, w_byte_r, rdata_r, rd_val, ar_idx;
   logic [1:0]  bresp_r, rresp_r;
   logic        wr_go, wr_en, ar_bad, ar_take;
   // Registers
   logic [7:0]  pwm_clock_and_pairing_r, pwm_clock_select_polarity_r;
   logic [3:0]  channel_enable_bit_r;
   logic        center_align_select_r;
   logic [7:0]  scale_value_r [2];
   logic [7:0]  scnt_r [2];
   logic [1:0]  half_r;
   logic [6:0]  pres_r;
   logic [7:0]  cnt_r [4];
   logic [7:0]  per_buf_r [4];
   logic [7:0]  dty_buf_r [4];
   logic [7:0]  per_act_r [4];
   logic [7:0]  dty_act_r [4];
   logic [3:0]  dn_r, pin_r, pin_oe_r;
   // Engine signals
   logic [1:0]  join_pair, ab_tick, s_tick, wr_scal;
   logic [3:0]  wr_cnt, wr_per, wr_dty, lane_on, run, tick, cclr;
   logic [3:0]  roll, load, wave, own, dn_nxt;
   logic [15:0] cnt16 [4];
   logic [15:0] per16 [4];
   logic [15:0] dty16 [4];
   logic [15:0] nxt16 [4];
   logic [7:0]  cnt_nxt [4];
   logic [7:0]  per_buf_nxt [4];
   logic [7:0]  dty_buf_nxt [4];
   logic [6:0]  mask [2];
   logic [2:0]  div [2];
   logic        any_en;

   function automatic logic idx_mapped(input logic [7:0] i);
      return (i >= fpc_pkg::IDX_CLKP) && (i <= fpc_pkg::IDX_CTL);
   endfunction

   // Channel whose engine drives channel c
   function automatic int src_ch(input int c, input logic [1:0] j);
      return j[c / 2] ? (c | 1) : c;
   endfunction

   assign s_axi_awready_out = !aw_full_r && !bvalid_r;
   assign s_axi_wready_out  = !w_full_r && !bvalid_r;
   assign s_axi_bvalid_out  = bvalid_r;
   assign s_axi_bresp_out   = bresp_r;
   assign s_axi_arready_out = !rvalid_r;
   assign s_axi_rvalid_out  = rvalid_r;
   assign s_axi_rresp_out   = rresp_r;
   assign s_axi_rdata_out   = {24'h00_0000, rdata_r};
   assign pin_out           = pin_r;
   assign pin_oe_out        = pin_oe_r;

   assign wr_go   = aw_full_r && w_full_r;
   assign wr_en   = wr_go && w_lane_r && !aw_bad_r;
   assign ar_idx  = s_axi_araddr_in[9:2];
   assign ar_bad  = (|s_axi_araddr_in[11:10]) || !idx_mapped(ar_idx);
   assign ar_take = s_axi_arvalid_in && !rvalid_r;

   // Write address and data taken in either order
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_full_r <= 1'b0;
         aw_idx_r  <= 8'h00;
         aw_bad_r  <= 1'b0;
      end else if (wr_go) begin
         aw_full_r <= 1'b0;
      end else if (s_axi_awvalid_in && s_axi_awready_out) begin
         aw_full_r <= 1'b1;
         aw_idx_r  <= s_axi_awaddr_in[9:2];
         aw_bad_r  <= (|s_axi_awaddr_in[11:10]) ||
                      !idx_mapped(s_axi_awaddr_in[9:2]);
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         w_full_r <= 1'b0;
         w_byte_r <= 8'h00;
         w_lane_r <= 1'b0;
      end else if (wr_go) begin
         w_full_r <= 1'b0;
      end else if (s_axi_wvalid_in && s_axi_wready_out) begin
         w_full_r <= 1'b1;
         w_byte_r <= s_axi_wdata_in[7:0];
         w_lane_r <= s_axi_wstrb_in[0];
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bvalid_r <= 1'b0;
         bresp_r  <= fpc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= aw_bad_r ? fpc_pkg::RESP_SLVERR : fpc_pkg::RESP_OKAY;
      end else if (s_axi_bready_in) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 8'h00;
         rresp_r  <= fpc_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r  <= ar_bad ? 8'h00 : rd_val;
         rresp_r  <= ar_bad ? fpc_pkg::RESP_SLVERR : fpc_pkg::RESP_OKAY;
      end else if (s_axi_rready_in) begin
         rvalid_r <= 1'b0;
      end
   end

   // Read multiplexer
   always_comb begin
      rd_val = 8'h00;
      case (ar_idx)
         fpc_pkg::IDX_CLKP:  rd_val = pwm_clock_and_pairing_r;
         fpc_pkg::IDX_POL:   rd_val = pwm_clock_select_polarity_r;
         fpc_pkg::IDX_EN:    rd_val = {4'h0, channel_enable_bit_r};
         fpc_pkg::IDX_PRES:  rd_val = {1'b0, pres_r};
         fpc_pkg::IDX_SCAL0: rd_val = scale_value_r[0];
         fpc_pkg::IDX_SCNT0: rd_val = scnt_r[0];
         fpc_pkg::IDX_SCAL1: rd_val = scale_value_r[1];
         fpc_pkg::IDX_SCNT1: rd_val = scnt_r[1];
         fpc_pkg::IDX_CTL:   rd_val = {7'h00, center_align_select_r};
         default: begin
            if (ar_idx[7:2] == fpc_pkg::IDX_CNT0[7:2]) begin
               rd_val = cnt_r[ar_idx[1:0]];
            end else if (ar_idx[7:2] == fpc_pkg::IDX_PER0[7:2]) begin
               rd_val = per_buf_r[ar_idx[1:0]];
            end else if (ar_idx[7:2] == fpc_pkg::IDX_DTY0[7:2]) begin
               rd_val = dty_buf_r[ar_idx[1:0]];
            end
         end
      endcase
   end

   // Control registers
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pwm_clock_and_pairing_r     <= fpc_pkg::RST_CLKP;
         pwm_clock_select_polarity_r <= fpc_pkg::RST_POL;
         channel_enable_bit_r        <= fpc_pkg::RST_EN;
         center_align_select_r       <= fpc_pkg::RST_CTL[0];
      end else if (wr_en) begin
         case (aw_idx_r)
            fpc_pkg::IDX_CLKP: pwm_clock_and_pairing_r <= w_byte_r;
            fpc_pkg::IDX_POL:  pwm_clock_select_polarity_r <= w_byte_r;
            fpc_pkg::IDX_EN:   channel_enable_bit_r <= w_byte_r[3:0];
            fpc_pkg::IDX_CTL:  center_align_select_r <= w_byte_r[0];
            default: ;
         endcase
      end
   end

   // Clock prescaler and scalers
   always_comb begin
      any_en    = |channel_enable_bit_r;
      div[0]    = pwm_clock_and_pairing_r[fpc_pkg::DIVA_LSB +: 3];
      div[1]    = pwm_clock_and_pairing_r[fpc_pkg::DIVB_LSB +: 3];
      wr_scal[0] = wr_en && (aw_idx_r == fpc_pkg::IDX_SCAL0);
      wr_scal[1] = wr_en && (aw_idx_r == fpc_pkg::IDX_SCAL1);
      for (int p = 0; p < 2; p++) begin
         mask[p]    = 7'((8'h01 << div[p]) - 8'h01);
         ab_tick[p] = any_en && ((pres_r & mask[p]) == mask[p]);
         s_tick[p]  = ab_tick[p] && (scnt_r[p] == 8'h00) && half_r[p];
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pres_r <= 7'h00;
      end else if (any_en) begin
         pres_r <= pres_r + 7'h01;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int p = 0; p < 2; p++) begin
            scale_value_r[p] <= fpc_pkg::RST_SCAL;
            scnt_r[p]        <= fpc_pkg::RST_SCAL;
         end
         half_r <= 2'b00;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (wr_scal[p]) begin
               scale_value_r[p] <= w_byte_r;
               scnt_r[p]        <= w_byte_r;
               half_r[p]        <= 1'b0;
            end else if (ab_tick[p]) begin
               // Reload every value+1 ticks, toggle halves them
               if (scnt_r[p] == 8'h00) begin
                  scnt_r[p] <= scale_value_r[p];
                  half_r[p] <= ~half_r[p];
               end else begin
                  scnt_r[p] <= scnt_r[p] - 8'h01;
               end
            end
         end
      end
   end

   // Channel engines
   always_comb begin
      join_pair[0] = pwm_clock_and_pairing_r[fpc_pkg::LOWER_JOIN_BIT];
      join_pair[1] = pwm_clock_and_pairing_r[fpc_pkg::UPPER_JOIN_BIT];
      for (int c = 0; c < 4; c++) begin
         wr_cnt[c] = wr_en && (aw_idx_r == fpc_pkg::IDX_CNT0 + 8'(c));
         wr_per[c] = wr_en && (aw_idx_r == fpc_pkg::IDX_PER0 + 8'(c));
         wr_dty[c] = wr_en && (aw_idx_r == fpc_pkg::IDX_DTY0 + 8'(c));
         per_buf_nxt[c] = wr_per[c] ? w_byte_r : per_buf_r[c];
         dty_buf_nxt[c] = wr_dty[c] ? w_byte_r : dty_buf_r[c];
         // Joined pair runs on its low-order channel
         lane_on[c] = !join_pair[c / 2] || (c % 2 == 1);
         run[c]     = channel_enable_bit_r[c] && lane_on[c];
         // Clock choice switches with no glitch guard
         tick[c] = run[c] &&
            (pwm_clock_select_polarity_r[fpc_pkg::CHOICE_LSB + c] ?
             s_tick[c / 2] : ab_tick[c / 2]);
         if (join_pair[c / 2] && (c % 2 == 1)) begin
            cnt16[c] = {cnt_r[c & 2], cnt_r[c]};
            per16[c] = {per_act_r[c & 2], per_act_r[c]};
            dty16[c] = {dty_act_r[c & 2], dty_act_r[c]};
         end else begin
            cnt16[c] = {8'h00, cnt_r[c]};
            per16[c] = {8'h00, per_act_r[c]};
            dty16[c] = {8'h00, dty_act_r[c]};
         end
         nxt16[c]  = cnt16[c];
         dn_nxt[c] = dn_r[c];
         roll[c]   = 1'b0;
         if (center_align_select_r) begin
            if (dn_r[c]) begin
               if (cnt16[c] <= 16'h0001) begin
                  nxt16[c]  = 16'h0000;
                  dn_nxt[c] = 1'b0;
                  roll[c]   = tick[c];
               end else begin
                  nxt16[c] = cnt16[c] - 16'h0001;
               end
            end else if (cnt16[c] >= per16[c]) begin
               if (per16[c] != 16'h0000) begin
                  nxt16[c]  = cnt16[c] - 16'h0001;
                  dn_nxt[c] = 1'b1;
               end else begin
                  nxt16[c] = 16'h0000;
                  roll[c]  = tick[c];
               end
            end else begin
               nxt16[c] = cnt16[c] + 16'h0001;
            end
         end else if (cnt16[c] >= per16[c]) begin
            nxt16[c] = 16'h0000;
            roll[c]  = tick[c];
         end else begin
            nxt16[c] = cnt16[c] + 16'h0001;
         end
         wave[c] = (cnt16[c] >= dty16[c]) ^ (!center_align_select_r &&
            pwm_clock_select_polarity_r[fpc_pkg::POL_LSB + c]);
      end
      for (int c = 0; c < 4; c++) begin
         cclr[c] = wr_cnt[c] || (join_pair[c / 2] && wr_cnt[c ^ 1]);
      end
      for (int c = 0; c < 4; c++) begin
         load[c] = !run[src_ch(c, join_pair)] ||
                   roll[src_ch(c, join_pair)] || cclr[c];
         cnt_nxt[c] = cnt_r[c];
         if (cclr[c]) begin
            cnt_nxt[c] = 8'h00;
         end else if (tick[src_ch(c, join_pair)]) begin
            cnt_nxt[c] = (src_ch(c, join_pair) == c) ? nxt16[c][7:0] :
                         nxt16[c | 1][15:8];
         end
         own[c] = join_pair[c / 2] ?
                  ((c % 2 == 0) && channel_enable_bit_r[c | 1]) :
                  channel_enable_bit_r[c];
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int c = 0; c < 4; c++) begin
            cnt_r[c] <= 8'h00;
         end
         dn_r <= 4'h0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            cnt_r[c] <= cnt_nxt[c];
            if (cclr[c]) begin
               dn_r[c] <= 1'b0;
            end else if (tick[c]) begin
               dn_r[c] <= dn_nxt[c];
            end
         end
      end
   end

   // Double-buffered period and duty
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int c = 0; c < 4; c++) begin
            per_buf_r[c] <= fpc_pkg::RST_PER;
            dty_buf_r[c] <= fpc_pkg::RST_DTY;
            per_act_r[c] <= fpc_pkg::RST_PER;
            dty_act_r[c] <= fpc_pkg::RST_DTY;
         end
      end else begin
         for (int c = 0; c < 4; c++) begin
            per_buf_r[c] <= per_buf_nxt[c];
            dty_buf_r[c] <= dty_buf_nxt[c];
            if (load[c]) begin
               per_act_r[c] <= per_buf_nxt[c];
               dty_act_r[c] <= dty_buf_nxt[c];
            end
         end
      end
   end

   // Pin ownership
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_r    <= 4'h0;
         pin_oe_r <= 4'h0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            pin_r[c]    <= own[c] ? wave[src_ch(c, join_pair)] :
                           gp_data_in[c];
            pin_oe_r[c] <= own[c] ? 1'b1 : gp_oe_in[c];
         end
      end
   end
endmodule // fpc_top

// ==== testbench/fpc_props.sv ====
// Bus handshake checker for the pwm clocking block
`timescale 1ns/1ps
module fpc_props (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // Write channels
   input  wire logic        s_axi_awvalid_in,
   input  wire logic        s_axi_awready_out,
   input  wire logic        s_axi_wvalid_in,
   input  wire logic        s_axi_wready_out,
   input  wire logic [1:0]  s_axi_bresp_out,
   input  wire logic        s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // Read channels
   input  wire logic [11:0] s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   input  wire logic        s_axi_arready_out,
   input  wire logic [31:0] s_axi_rdata_out,
   input  wire logic [1:0]  s_axi_rresp_out,
   input  wire logic        s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_b_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("b drop");
   a_r_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("r drop");
   a_aw_refused: assert property (s_axi_bvalid_out
      |-> !s_axi_awready_out && !s_axi_wready_out) else $error("aw ready");
   a_ar_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("ar ready");
   a_w_answer: assert property (s_axi_awvalid_in && s_axi_awready_out &&
      s_axi_wvalid_in && s_axi_wready_out
      |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out) else $error("b late");
   a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out) else $error("r late");
   a_r_upper: assert property (s_axi_rvalid_out
      |-> s_axi_rdata_out[31:8] == 24'h00_0000) else $error("r upper");
   a_r_unmapped: assert property (s_axi_arvalid_in && s_axi_arready_out &&
      s_axi_araddr_in[11:10] != 2'b00 |=> s_axi_rresp_out ==
      fpc_pkg::RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000)
      else $error("r unmapped");
   a_b_legal: assert property (s_axi_bvalid_out |->
      s_axi_bresp_out[0] == 1'b0) else $error("b code");
endmodule // fpc_props

// ==== testbench/fpc_top_tb_top.sv ====
// Self-checking bench for the pwm clocking block
`timescale 1ns/1ps
module fpc_top_tb_top;
   logic        clk = 1'b0, rst_n = 1'b0;
   logic [11:0] awa = 12'h000, ara = 12'h000;
   logic [31:0] wd = 32'h0000_0000, rnd = 32'h5763, gs = 32'h5763;
   logic [3:0]  ws = 4'h0, gd = 4'h0, go = 4'h0;
   logic        awv = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rq = 1'b0;
   wire  logic  awrdy, wrdy, bv, arrdy, rv;
   wire  logic [1:0]  br, rr;
   wire  logic [31:0] rd;
   wire  logic [3:0]  po, poe;
   int          error_cnt = 0, num_checks = 0;
   always #12.5 clk = ~clk;
   fpc_top dut (.clk_in(clk), .arst_n_in(rst_n), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(bq), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arrdy), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rq), .gp_data_in(gd),
      .gp_oe_in(go), .pin_out(po), .pin_oe_out(poe));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   // High cycles of a left-aligned wave over n periods
   function automatic int hi_exp(int per, int dty, int pol, int n);
      return n * (pol != 0 ? dty : per + 1 - dty);
   endfunction
   // High cycles of a center-aligned wave over n periods
   function automatic int ctr_hi(int per, int dty, int n);
      return n * (dty == 0 ? 2 * per : 2 * (per - dty) + 1);
   endfunction
   task automatic finish_test;
      if (error_cnt == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er = fpc_pkg::RESP_OKAY);
      int k;
      @(posedge clk);
      awa <= a;
      wd  <= {24'h00_0000, d};
      ws  <= 4'hf;
      awv <= 1'b1;
      wv  <= 1'b1;
      k = 0;
      forever begin
         @(posedge clk);
         if (awrdy) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         if (bv && bq) break;
         if (bv) bq <= 1'b1;
         k++;
      end
      bq <= 1'b0;
      chk(k, 3, "write latency");
      chk(br, er, "write response");
   endtask
   task automatic rc(input logic [11:0] a, input logic [7:0] e,
                     input logic [1:0] er = fpc_pkg::RESP_OKAY);
      int k;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      k = 0;
      forever begin
         @(posedge clk);
         if (arrdy) arv <= 1'b0;
         if (rv && rq) break;
         if (rv) rq <= 1'b1;
         k++;
      end
      rq <= 1'b0;
      chk(k, 2, "read latency");
      chk(rd, {24'h00_0000, e}, "read data");
      chk(rr, er, "read response");
   endtask
   task automatic meas(input int ch, input int n, input logic [3:0] own,
                       output int h);
      logic [3:0] g, o;
      h = 0;
      repeat (n) begin
         @(posedge clk);
         g = gd;
         o = go;
         #1;
         if (po[ch] === 1'b1) h++;
         for (int i = 0; i < 4; i++) begin
            if (own[i])
               chk(poe[i] & (po[i] | ~po[i]), 1, "pin drive");
            else chk({poe[i], po[i]}, {o[i], g[i]}, "gp pin");
         end
      end
   endtask
   // General-purpose drive changes every cycle
   always @(posedge clk) begin
      gs <= nx(gs);
      gd <= gs[3:0];
      go <= gs[7:4];
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      int per, dty, pol, dv, o, cs, sc, h, t, e, p, x;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 8'h40; i <= 8'h54; i++)
         rc(ad(8'(i)), (i >= 8'h4C && i < 8'h54) ? 8'hFF : 8'h00);
      wr(ad(8'h3F), 8'h5A, fpc_pkg::RESP_SLVERR);
      wr(12'h500, 8'h5A, fpc_pkg::RESP_SLVERR);
      rc(ad(8'h55), 8'h00, fpc_pkg::RESP_SLVERR);
      rc(12'h500, 8'h00, fpc_pkg::RESP_SLVERR);
      wr(ad(fpc_pkg::IDX_PRES), 8'h7F);
      rc(ad(fpc_pkg::IDX_PRES), 8'h00);
      rnd = nx(rnd);
      wr(ad(fpc_pkg::IDX_CLKP), rnd[7:0]);
      rc(ad(fpc_pkg::IDX_CLKP), rnd[7:0]);
      wr(ad(fpc_pkg::IDX_POL), rnd[15:8]);
      rc(ad(fpc_pkg::IDX_POL), rnd[15:8]);
      for (int ch = 0; ch < 4; ch++) begin
         rnd = nx(rnd);
         per = 3 + rnd[3:0];
         dty = (ch == 0) ? 0 : rnd[11:8] % (per + 1);
         pol = rnd[12];
         dv = rnd[14:13] % 3;
         o = dv ^ 1;
         cs = rnd[15];
         sc = rnd[17:16];
         wr(ad(8'(fpc_pkg::IDX_PER0 + ch)), 8'(per));
         wr(ad(8'(fpc_pkg::IDX_DTY0 + ch)), 8'(dty));
         wr(ad(fpc_pkg::IDX_CLKP), ch < 2 ? {2'b00, 3'(dv), 3'(o)}
            : {2'b00, 3'(o), 3'(dv)});
         wr(ad(fpc_pkg::IDX_POL), 8'((cs << (4 + ch)) | (pol << ch)));
         wr(ad(fpc_pkg::IDX_SCAL0), 8'(ch < 2 ? sc : sc ^ 1));
         wr(ad(fpc_pkg::IDX_SCAL1), 8'(ch < 2 ? sc ^ 1 : sc));
         wr(ad(8'(fpc_pkg::IDX_CNT0 + ch)), 8'h00);
         wr(ad(fpc_pkg::IDX_EN), 8'(1 << ch));
         // Clock cycles per counter step
         e = (1 << dv) * (cs != 0 ? 2 * (sc + 1) : 1);
         t = (per + 1) * e;
         repeat (t + 4) @(posedge clk);
         meas(ch, 2 * t, 4'(1 << ch), h);
         x = hi_exp(per, dty, pol, 2 * e);
         chk(h, x, "high time");
         // One period alone must hold the same share
         meas(ch, t, 4'(1 << ch), h);
         x = hi_exp(per, dty, pol, e);
         chk(h, x, "rate");
         rc(ad(8'(fpc_pkg::IDX_PER0 + ch)), 8'(per));
         wr(ad(fpc_pkg::IDX_EN), 8'h00);
      end
      wr(ad(fpc_pkg::IDX_CLKP), 8'h00);
      wr(ad(fpc_pkg::IDX_POL), 8'h00);
      wr(ad(fpc_pkg::IDX_PER0), 8'hFF);
      wr(ad(fpc_pkg::IDX_DTY0), 8'hFF);
      wr(ad(fpc_pkg::IDX_CNT0), 8'h00);
      wr(ad(fpc_pkg::IDX_EN), 8'h01);
      wr(ad(fpc_pkg::IDX_DTY0), 8'h00);
      meas(0, 150, 4'h1, h);
      chk(h, 0, "duty took effect early");
      rc(ad(fpc_pkg::IDX_DTY0), 8'h00);
      wr(ad(fpc_pkg::IDX_CNT0), 8'h00);
      repeat (3) @(posedge clk);
      meas(0, 50, 4'h1, h);
      chk(h, 50, "forced duty");
      wr(ad(fpc_pkg::IDX_EN), 8'h00);
      // Center-aligned, polarity set but ignored
      wr(ad(fpc_pkg::IDX_CTL), 8'h01);
      wr(ad(fpc_pkg::IDX_PER0), 8'h08);
      wr(ad(fpc_pkg::IDX_DTY0), 8'h03);
      wr(ad(fpc_pkg::IDX_POL), 8'h01);
      wr(ad(fpc_pkg::IDX_CNT0), 8'h00);
      wr(ad(fpc_pkg::IDX_EN), 8'h01);
      repeat (20) @(posedge clk);
      meas(0, 32, 4'h1, h);
      x = ctr_hi(8, 3, 2);
      chk(h, x, "centered");
      wr(ad(fpc_pkg::IDX_EN), 8'h00);
      wr(ad(fpc_pkg::IDX_CTL), 8'h00);
      wr(ad(fpc_pkg::IDX_SCAL0), 8'h00);
      wr(ad(fpc_pkg::IDX_SCAL1), 8'h00);
      for (p = 0; p < 2; p++) begin
         e = 2 * p;
         wr(ad(8'(fpc_pkg::IDX_PER0 + e)), 8'h00);
         wr(ad(8'(fpc_pkg::IDX_PER0 + e + 1)), 8'h0F);
         wr(ad(8'(fpc_pkg::IDX_DTY0 + e)), 8'h00);
         wr(ad(8'(fpc_pkg::IDX_DTY0 + e + 1)), 8'h05);
         wr(ad(fpc_pkg::IDX_CLKP), p != 0 ? 8'h80 : 8'h40);
         wr(ad(fpc_pkg::IDX_POL), 8'(1 << (5 + e)));
         wr(ad(8'(fpc_pkg::IDX_CNT0 + e + 1)), 8'h00);
         wr(ad(fpc_pkg::IDX_EN), 8'(1 << (e + 1)));
         repeat (40) @(posedge clk);
         meas(e, 64, 4'(1 << e), h);
         chk(h, 44, "joined pair");
         wr(ad(fpc_pkg::IDX_EN), 8'h00);
      end
      finish_test();
   end
endmodule // fpc_top_tb_top
bind fpc_top fpc_props u_props (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
   .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
   .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in));
